// file: src/reductant_pump_control.sv
`timescale 1ns/1ps
// Behaviour
// - in analogue mode the level comes from the ecu over can, parameter 1761
// - with contact mode selected, contacts decide the level and can is ignored
// - status: below start is start, else above stop is stop, else hysteresis
// - automatic: start turns pump on, stop turns off, hysteresis holds
// - manual: operator switches pump, start refused while status is stop
// - continuous run past max duration stops pump and raises timeout prealarm
// - after timeout pump stays off until the operator acknowledges
// - pump and solenoid commands exposed as two status bits
// - with logging enabled, pulse events on each pump turn-on and turn-off
// - modes: automatic, manual on, manual off
// - solenoid opens delay before pump start, closes delay after pump stop
// - supply source select; pump stops while the chosen source is absent
// - off/reset operating mode holds the pump off
module reductant_pump_control #(
  parameter int tick_len = pump_pkg::tick_cycles
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] pump_mode,
  input wire logic contact_mode,
  input wire logic [pump_pkg::level_w-1:0] can_level,
  input wire logic [pump_pkg::level_w-1:0] start_threshold,
  input wire logic [pump_pkg::level_w-1:0] stop_threshold,
  input wire logic start_contact_input,
  input wire logic stop_contact_input,
  input wire logic manual_start_req,
  input wire logic manual_stop_req,
  input wire logic [pump_pkg::sec_w-1:0] max_run_sec,
  input wire logic [pump_pkg::sec_w-1:0] solenoid_delay_sec,
  input wire logic solenoid_enable,
  input wire logic [2:0] supply_select,
  input wire logic [3:0] source_present,
  input wire logic off_reset_mode,
  input wire logic timeout_ack,
  input wire logic event_log_enable,
  output logic pump_output,
  output logic solenoid_output,
  output logic pump_cmd_state,
  output logic solenoid_cmd_state,
  output logic pump_timeout_prealarm,
  output logic pump_on_event,
  output logic pump_off_event
);
  // ===========================================================================
  // level evaluation
  level_if lvl ();

  level_eval u_eval (
    .mclk(mclk),
    .reset_n(reset_n),
    .contact_mode(contact_mode),
    .can_level(can_level),
    .start_threshold(start_threshold),
    .stop_threshold(stop_threshold),
    .start_contact_input(start_contact_input),
    .stop_contact_input(stop_contact_input),
    .lvl(lvl)
  );

  // ===========================================================================
  // second tick: time base for the solenoid delay; the run timer keeps its own prescaler
  // cycles per second; a bench may shorten it so timeouts fit a short run
  localparam logic [25:0] tick_last = 26'(tick_len - 1);
  logic [25:0] presc_ff;
  logic [25:0] nxt_presc;
  logic tick;

  always_comb begin
    tick = (presc_ff == tick_last);
    nxt_presc = tick ? 26'h000_0000 : presc_ff + 26'h000_0001;
  end

  // ===========================================================================
  // pump request logic
  logic want_ff;
  logic nxt_want;
  logic timeout_ff;
  logic nxt_timeout;
  logic [pump_pkg::sec_w-1:0] run_ff;
  logic [pump_pkg::sec_w-1:0] nxt_run;
  logic [25:0] run_presc_ff;
  logic [25:0] nxt_run_presc;
  logic supply_ok;
  logic inhibit;
  logic expired;

  // source availability; always-present code disables the check
  always_comb begin
    case (supply_select)
      pump_pkg::src_generator: supply_ok = source_present[0];
      pump_pkg::src_bars: supply_ok = source_present[1];
      pump_pkg::src_users: supply_ok = source_present[2];
      pump_pkg::src_mains: supply_ok = source_present[3];
      pump_pkg::src_always: supply_ok = 1'b1;
      default: supply_ok = 1'b1;
    endcase
  end

  assign inhibit = off_reset_mode || !supply_ok || timeout_ff;
  assign expired = pump_cmd_state && (run_ff >= max_run_sec) && (run_presc_ff == tick_last);

  // next pump request by mode; holds in hysteresis
  always_comb begin
    nxt_want = want_ff;
    case (pump_pkg::mode_t'(pump_mode))
      pump_pkg::mode_auto: begin
        if (lvl.status == pump_pkg::lvl_start) begin
          nxt_want = 1'b1;
        end else if (lvl.status == pump_pkg::lvl_stop) begin
          nxt_want = 1'b0;
        end
      end
      pump_pkg::mode_manual_on_mode: begin
        if (manual_stop_req) begin
          nxt_want = 1'b0;
        end else if (manual_start_req && lvl.status != pump_pkg::lvl_stop) begin
          nxt_want = 1'b1;
        end
        if (lvl.status == pump_pkg::lvl_stop) begin
          nxt_want = 1'b0;
        end
      end
      pump_pkg::mode_manual_off_mode: nxt_want = 1'b0;
      default: nxt_want = 1'b0;
    endcase
    if (inhibit || expired) begin
      nxt_want = 1'b0;
    end
  end

  // timeout latch: expiry wins over a same-cycle acknowledge
  always_comb begin
    nxt_timeout = timeout_ff;
    if (timeout_ack) begin
      nxt_timeout = 1'b0;
    end
    if (expired) begin
      nxt_timeout = 1'b1;
    end
  end

  // run timer counts whole seconds from turn-on, cleared while pump is off
  always_comb begin
    if (!pump_cmd_state) begin
      nxt_run = '0;
      nxt_run_presc = 26'h000_0000;
    end else if (run_presc_ff == tick_last) begin
      nxt_run = (run_ff == '1) ? run_ff : run_ff + 1'b1;
      nxt_run_presc = 26'h000_0000;
    end else begin
      nxt_run = run_ff;
      nxt_run_presc = run_presc_ff + 26'h000_0001;
    end
  end

  // ===========================================================================
  // solenoid sequencing: valve leads pump on start and lags on stop
  typedef enum logic [1:0] {
    sq_idle = 2'b00,
    sq_open = 2'b01,
    sq_run = 2'b11,
    sq_close = 2'b10
  } seq_t;
  seq_t seq_ff;
  seq_t nxt_seq;
  logic [pump_pkg::sec_w-1:0] dly_ff;
  logic [pump_pkg::sec_w-1:0] nxt_dly;
  logic pump_ff;
  logic nxt_pump;
  logic sol_ff;
  logic nxt_sol;

  always_comb begin
    nxt_seq = seq_ff;
    nxt_dly = dly_ff;
    if (tick && dly_ff != '0) begin
      nxt_dly = dly_ff - 1'b1;
    end
    case (seq_ff)
      sq_idle: begin
        if (want_ff) begin
          nxt_seq = (solenoid_enable && solenoid_delay_sec != '0) ? sq_open : sq_run;
          nxt_dly = solenoid_delay_sec;
        end
      end
      sq_open: begin
        if (!want_ff) begin
          nxt_seq = sq_idle;
        end else if (dly_ff == '0) begin
          nxt_seq = sq_run;
        end
      end
      sq_run: begin
        if (!want_ff) begin
          nxt_seq = (solenoid_enable && solenoid_delay_sec != '0) ? sq_close : sq_idle;
          nxt_dly = solenoid_delay_sec;
        end
      end
      sq_close: begin
        if (dly_ff == '0) begin
          nxt_seq = sq_idle;
        end
      end
      default: nxt_seq = sq_idle;
    endcase
    // pump only runs in sq_run and never while inhibited
    nxt_pump = (nxt_seq == sq_run) && !inhibit && !expired;
    nxt_sol = solenoid_enable && (nxt_seq != sq_idle);
  end

  // ===========================================================================
  // event pulses on pump command edges
  logic on_ev_ff;
  logic off_ev_ff;
  logic nxt_on_ev;
  logic nxt_off_ev;

  always_comb begin
    nxt_on_ev = event_log_enable && nxt_pump && !pump_ff;
    nxt_off_ev = event_log_enable && !nxt_pump && pump_ff;
  end

  // ===========================================================================
  // all state registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      presc_ff <= 26'h000_0000;
      want_ff <= 1'b0;
      timeout_ff <= 1'b0;
      run_ff <= '0;
      run_presc_ff <= 26'h000_0000;
      seq_ff <= sq_idle;
      dly_ff <= '0;
      pump_ff <= 1'b0;
      sol_ff <= 1'b0;
      on_ev_ff <= 1'b0;
      off_ev_ff <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      want_ff <= nxt_want;
      timeout_ff <= nxt_timeout;
      run_ff <= nxt_run;
      run_presc_ff <= nxt_run_presc;
      seq_ff <= nxt_seq;
      dly_ff <= nxt_dly;
      pump_ff <= nxt_pump;
      sol_ff <= nxt_sol;
      on_ev_ff <= nxt_on_ev;
      off_ev_ff <= nxt_off_ev;
    end
  end

  assign pump_output = pump_ff;
  assign solenoid_output = sol_ff;
  assign pump_cmd_state = pump_ff;
  assign solenoid_cmd_state = sol_ff;
  assign pump_timeout_prealarm = timeout_ff;
  assign pump_on_event = on_ev_ff;
  assign pump_off_event = off_ev_ff;

  // ===========================================================================
  // checks
  property p_off_reset;
    @(posedge mclk) disable iff (!reset_n) off_reset_mode |=> !pump_ff;
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("pump on in off/reset");

  property p_supply;
    @(posedge mclk) disable iff (!reset_n) !supply_ok |=> !pump_ff;
  endproperty
  a_supply: assert property (p_supply) else $error("pump on without supply");

  property p_timeout_holds;
    @(posedge mclk) disable iff (!reset_n)
      (timeout_ff && !timeout_ack) |=> (timeout_ff && !pump_ff);
  endproperty
  a_timeout_holds: assert property (p_timeout_holds) else $error("timeout released");

  property p_expire;
    @(posedge mclk) disable iff (!reset_n) expired |=> (timeout_ff && !pump_ff);
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not stop pump");

  property p_run_clear;
    @(posedge mclk) disable iff (!reset_n) !pump_ff |=> (run_ff == '0);
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run timer not cleared");

  property p_man_refuse;
    @(posedge mclk) disable iff (!reset_n)
      (pump_mode == pump_pkg::mode_manual_on_mode && lvl.status == pump_pkg::lvl_stop) |=> !want_ff;
  endproperty
  a_man_refuse: assert property (p_man_refuse) else $error("start at stop level");

  property p_manual_off_mode;
    @(posedge mclk) disable iff (!reset_n)
      (pump_mode == pump_pkg::mode_manual_off_mode) |=> !want_ff;
  endproperty
  a_manual_off_mode: assert property (p_manual_off_mode) else $error("request in manual off");

  property p_auto_start;
    @(posedge mclk) disable iff (!reset_n)
      (pump_mode == pump_pkg::mode_auto && lvl.status == pump_pkg::lvl_start && !inhibit
       && !expired) |=> want_ff;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto start missed");

  property p_on_event;
    @(posedge mclk) disable iff (!reset_n)
      ($rose(pump_ff) && $past(event_log_enable)) |-> on_ev_ff;
  endproperty
  a_on_event: assert property (p_on_event) else $error("missing on event");

  property p_sol_lead;
    @(posedge mclk) disable iff (!reset_n) $rose(pump_ff) && solenoid_enable |-> sol_ff;
  endproperty
  a_sol_lead: assert property (p_sol_lead) else $error("pump before solenoid");

  c_pump_on: cover property (@(posedge mclk) $rose(pump_ff));
  c_timeout: cover property (@(posedge mclk) $rose(timeout_ff));
  c_close_seq: cover property (@(posedge mclk) seq_ff == sq_close);
endmodule // reductant_pump_control

// file: include/pump_pkg.sv
package pump_pkg;
  // ===========================================================================
  // level status and pump modes
  typedef enum logic [1:0] {
    lvl_hyst = 2'b00,
    lvl_start = 2'b01,
    lvl_stop = 2'b11
  } level_t;

  typedef enum logic [1:0] {
    mode_auto = 2'b00,
    mode_manual_on_mode = 2'b01,
    mode_manual_off_mode = 2'b11
  } mode_t;

  // pump supply source codes
  localparam logic [2:0] src_generator = 3'h0;
  localparam logic [2:0] src_bars = 3'h1;
  localparam logic [2:0] src_users = 3'h2;
  localparam logic [2:0] src_mains = 3'h3;
  localparam logic [2:0] src_always = 3'h4;

  // ===========================================================================
  // timing: one tick per second of the 50 MHz clock
  localparam int clk_hz = 50_000_000;
  localparam int tick_s = 1;
  localparam int tick_cycles = clk_hz * tick_s;
  localparam int level_w = 16;
  localparam int sec_w = 16;
endpackage

// file: include/pump_if.sv
`timescale 1ns/1ps
// level evaluation result passed from the evaluator to the controller
interface level_if;
  logic [1:0] status;
  modport evaluator (output status);
  modport consumer (input status);
endinterface

// file: src/level_eval.sv
`timescale 1ns/1ps
// ===========================================================================
// level classifier: registered so settings take effect on the next cycle
module level_eval (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic contact_mode,
  input wire logic [pump_pkg::level_w-1:0] can_level,
  input wire logic [pump_pkg::level_w-1:0] start_threshold,
  input wire logic [pump_pkg::level_w-1:0] stop_threshold,
  input wire logic start_contact_input,
  input wire logic stop_contact_input,
  level_if.evaluator lvl
);
  logic [1:0] status_ff;
  logic [1:0] nxt_status;

  // priority: start first, then stop, else hysteresis
  always_comb begin
    if (contact_mode) begin
      // start contact closed means below start; stop contact open means above stop
      if (start_contact_input) begin
        nxt_status = pump_pkg::lvl_start;
      end else if (!stop_contact_input) begin
        nxt_status = pump_pkg::lvl_stop;
      end else begin
        nxt_status = pump_pkg::lvl_hyst;
      end
    end else begin
      // level taken from the engine ecu value received over can
      if (can_level < start_threshold) begin
        nxt_status = pump_pkg::lvl_start;
      end else if (can_level > stop_threshold) begin
        nxt_status = pump_pkg::lvl_stop;
      end else begin
        nxt_status = pump_pkg::lvl_hyst;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= pump_pkg::lvl_hyst;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign lvl.status = status_ff;

  property p_eval_start;
    @(posedge mclk) disable iff (!reset_n)
      (contact_mode && start_contact_input) |=> (status_ff == pump_pkg::lvl_start);
  endproperty
  a_eval_start: assert property (p_eval_start) else $error("start contact not classified");

  property p_eval_can_ignored;
    @(posedge mclk) disable iff (!reset_n)
      (contact_mode && !start_contact_input && stop_contact_input)
        |=> (status_ff == pump_pkg::lvl_hyst);
  endproperty
  a_eval_can_ignored: assert property (p_eval_can_ignored) else $error("can level used");
endmodule // level_eval

// file: test/tank_model.sv
`timescale 1ns/1ps
// ===========================================================================
// far side: engine ecu level report and the two tank level contacts
module tank_model (
  input wire logic [pump_pkg::level_w-1:0] level,
  input wire logic [pump_pkg::level_w-1:0] start_th,
  input wire logic [pump_pkg::level_w-1:0] stop_th,
  input wire logic mirror,
  output logic [pump_pkg::level_w-1:0] can_level,
  output logic start_contact_input,
  output logic stop_contact_input
);
  // ecu reports the level it measures; mirror makes it disagree with the contacts
  always_comb begin
    can_level = mirror ? 16'h012c - level : level;
    start_contact_input = level < start_th;
    stop_contact_input = level < stop_th;
  end
endmodule // tank_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [1:0] mode;
    logic cm;
    logic [15:0] lvl;
    logic sreq;
    logic preq;
    logic exp;
  } row_t;
  logic mclk, reset_n, contact_mode, mirror, start_req, stop_req, off_reset, ack;
  logic [1:0] pump_mode;
  logic [2:0] supply_select;
  logic [3:0] source_present;
  logic [15:0] level, can_level, start_th, stop_th;
  logic start_c, stop_c, pump_output, solenoid_output, pump_st, sol_st, prealarm;
  logic on_ev, off_ev, prev_pump, sol_en, log_en, prev_log;
  logic [15:0] sol_dly;
  int err_total = 0;
  int checks = 0;
  row_t rows [14];

  tank_model far (.level(level), .start_th(start_th), .stop_th(stop_th), .mirror(mirror),
    .can_level(can_level), .start_contact_input(start_c), .stop_contact_input(stop_c));

  // ten-cycle second keeps the run limit and valve delays inside a short run
  reductant_pump_control #(.tick_len(10)) dut (.mclk(mclk), .reset_n(reset_n),
    .pump_mode(pump_mode),
    .contact_mode(contact_mode), .can_level(can_level), .start_threshold(start_th),
    .stop_threshold(stop_th), .start_contact_input(start_c), .stop_contact_input(stop_c),
    .manual_start_req(start_req), .manual_stop_req(stop_req), .max_run_sec(16'h0005),
    .solenoid_delay_sec(sol_dly), .solenoid_enable(sol_en), .supply_select(supply_select),
    .source_present(source_present), .off_reset_mode(off_reset), .timeout_ack(ack),
    .event_log_enable(log_en), .pump_output(pump_output), .solenoid_output(solenoid_output),
    .pump_cmd_state(pump_st), .solenoid_cmd_state(sol_st),
    .pump_timeout_prealarm(prealarm), .pump_on_event(on_ev), .pump_off_event(off_ev));

  // ===========================================================================
  // clock and helpers
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic chk(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  // status, request and pump stages need three cycles; six leaves margin
  task automatic settle_pump(input logic exp);
    step(6);
    chk("pump_output", exp, pump_output);
    chk("pump_cmd_state", exp, pump_st);
    chk("solenoid_output", sol_en & exp, solenoid_output);
    chk("solenoid_cmd_state", sol_en & exp, sol_st);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ===========================================================================
  // event pulses must coincide with every change of the pump command while logging is enabled
  always @(posedge mclk) begin
    if (!reset_n) begin
      prev_pump <= 1'b0;
      prev_log <= log_en;
    end else begin
      chk("pump_on_event", pump_output & ~prev_pump & prev_log, on_ev);
      chk("pump_off_event", ~pump_output & prev_pump & prev_log, off_ev);
      prev_pump <= pump_output;
      prev_log <= log_en;
    end
  end

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end

  // ===========================================================================
  // main sequence
  initial begin
    reset_n = 1'b0;
    pump_mode = 2'b00;
    contact_mode = 1'b0;
    mirror = 1'b0;
    level = 16'h0096;
    start_th = 16'h0064; // start kept below stop
    stop_th = 16'h00c8;
    start_req = 1'b0;
    stop_req = 1'b0;
    off_reset = 1'b0;
    ack = 1'b0;
    sol_en = 1'b0;
    sol_dly = 16'h0002;
    log_en = 1'b1;
    supply_select = pump_pkg::src_always;
    source_present = 4'h0;
    rows = '{
      '{2'b00, 0, 16'h0032, 0, 0, 1}, '{2'b00, 0, 16'h0096, 0, 0, 1},
      '{2'b00, 0, 16'h00fa, 0, 0, 0}, '{2'b00, 0, 16'h0096, 0, 0, 0},
      '{2'b00, 1, 16'h0032, 0, 0, 1}, '{2'b00, 1, 16'h00fa, 0, 0, 0},
      '{2'b11, 0, 16'h0032, 0, 0, 0}, '{2'b01, 0, 16'h0096, 1, 0, 1},
      '{2'b01, 0, 16'h0096, 0, 1, 0}, '{2'b01, 0, 16'h00fa, 1, 0, 0},
      '{2'b01, 0, 16'h0096, 1, 0, 1}, '{2'b01, 0, 16'h00fa, 0, 0, 0},
      '{2'b10, 0, 16'h0032, 0, 0, 0}, '{2'b00, 0, 16'h0032, 0, 0, 1}};
    step(4);
    chk("reset pump_output", 1'b0, pump_output);
    chk("reset prealarm", 1'b0, prealarm);
    reset_n = 1'b1;
    step(1);
    // table: level, mode and operator requests; contact rows get a contrary ecu value
    foreach (rows[i]) begin
      pump_mode = rows[i].mode;
      contact_mode = rows[i].cm;
      mirror = rows[i].cm;
      level = rows[i].lvl;
      // requests are judged against the registered status, so let the level settle first
      step(2);
      start_req = rows[i].sreq;
      stop_req = rows[i].preq;
      step(1);
      start_req = 1'b0;
      stop_req = 1'b0;
      settle_pump(rows[i].exp);
    end
    // off/reset forces the pump off while the level asks for it
    off_reset = 1'b1;
    settle_pump(1'b0);
    off_reset = 1'b0;
    settle_pump(1'b1);
    // supply from mains, mains missing then back
    supply_select = pump_pkg::src_mains;
    source_present = 4'b0111;
    settle_pump(1'b0);
    source_present = 4'b1000;
    settle_pump(1'b1);
    supply_select = pump_pkg::src_bars;
    source_present = 4'b1101;
    settle_pump(1'b0);
    supply_select = pump_pkg::src_users;
    source_present = 4'b0100;
    settle_pump(1'b1);
    supply_select = pump_pkg::src_generator;
    source_present = 4'b1110;
    settle_pump(1'b0);
    supply_select = pump_pkg::src_always;
    settle_pump(1'b1);
    // an acknowledge with no pending timeout leaves the prealarm low
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    settle_pump(1'b1);
    chk("pump_timeout_prealarm", 1'b0, prealarm);
    // second reset in mid-run drops the pump at once
    reset_n = 1'b0;
    #1;
    chk("mid reset pump_output", 1'b0, pump_output);
    step(2);
    reset_n = 1'b1;
    settle_pump(1'b1);
    // run past the limit: pump stops and stays stopped until acknowledged
    step(60);
    chk("pump_timeout_prealarm", 1'b1, prealarm);
    chk("expired pump_output", 1'b0, pump_output);
    step(5);
    chk("held pump_output", 1'b0, pump_output);
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    settle_pump(1'b1);
    chk("acked prealarm", 1'b0, prealarm);
    // valve lags the stop and leads the start by two ticks; events muted meanwhile
    sol_en = 1'b1;
    log_en = 1'b0;
    level = 16'h00fa;
    step(6);
    chk("lag pump_output", 1'b0, pump_output);
    chk("lag solenoid_output", 1'b1, solenoid_output);
    step(40);
    chk("closed solenoid_output", 1'b0, solenoid_output);
    level = 16'h0032;
    step(6);
    chk("lead pump_output", 1'b0, pump_output);
    chk("lead solenoid_output", 1'b1, solenoid_output);
    step(40);
    chk("late pump_output", 1'b1, pump_output);
    chk("late solenoid_cmd_state", 1'b1, sol_st);
    wrap_up();
  end
endmodule // testbench
